//--- sbc_fifo.sv
`timescale 1ns/1ns
module sbc_fifo #(
  parameter int WIDTH = sbc_pkg::FIFO_WIDTH,
  parameter int DEPTH = sbc_pkg::FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // ==========================================================
  // pointers and storage
  always_comb begin
    push = i_valid && (cnt_reg != (AW+1)'(DEPTH));
    pop = i_ready && (cnt_reg != '0);
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (push) begin
      mem_next[wr_reg] = i_data;
      wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : AW'(wr_reg + 1'b1);
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : AW'(rd_reg + 1'b1);
    end
    cnt_next = (AW+1)'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge i_clock) begin
    mem_reg <= mem_next;
    if (i_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  assign o_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_valid = (cnt_reg != '0);
  assign o_data = mem_reg[rd_reg];
endmodule // sbc_fifo

//--- sbc_host_model.sv
`timescale 1ns/1ns
module sbc_host_model (
  input wire logic i_clock,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_low,
  output logic o_sda_low,
  output logic o_hang
);
  // ==========================================================
  // open-drain host, quarter bit = 2 clocks, bit = 160 ns
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    o_hang = 1'b0;
  end
  task automatic q();
    repeat (2) @(posedge i_clock);
    #1;
  endtask
  // extra quarters let the target let go of sda first
  task automatic start_cond();
    q();
    q();
    o_sda_low = 1'b0;
    q();
    o_scl_low = 1'b0;
    q();
    q();
    o_sda_low = 1'b1;
    q();
    o_scl_low = 1'b1;
  endtask
  task automatic stop_cond();
    q();
    o_sda_low = 1'b1;
    q();
    o_scl_low = 1'b0;
    q();
    o_sda_low = 1'b0;
    q();
    q();
  endtask
  task automatic bit_io(input logic b, output logic r);
    int n;
    q();
    o_sda_low = ~b;
    q();
    o_scl_low = 1'b0;
    n = 0;
    // target may stretch the low phase
    while (i_scl !== 1'b1 && n < 4000) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    if (n >= 4000) o_hang = 1'b1;
    q();
    r = i_sda;
    q();
    o_scl_low = 1'b1;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // sbc_host_model

//--- sbc_pkg.sv
package sbc_pkg;
  // ==========================================================
  // bus address and latch timing
  localparam logic [3:0] ADDR_HIGH = 4'hd;
  localparam logic [1:0] LATCH_DELAY = 2'h3;
  // ==========================================================
  // configuration store
  localparam int NUM_LOC = 8;
  localparam logic [7:0] BYTE_COUNT = 8'h08;
  // identity bytes: values arbitrary
  localparam logic [7:0] REV_VENDOR_BYTE = 8'h10;
  localparam logic [7:0] DEV_ID_BYTE = 8'h20;
  // byte 7 at the top, byte 0 at the bottom
  localparam logic [63:0] CFG_RESET = {BYTE_COUNT, DEV_ID_BYTE, REV_VENDOR_BYTE, 8'hff,
                                       8'hc7, 8'hff, 8'h4e, 8'hff};
  // identity bytes are read only
  localparam logic [7:0] RO_MASK = 8'h60;
  // ==========================================================
  // write buffer
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  // ==========================================================
  // state and byte role
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_RX_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_TX_ACK = 6'h10,
    ST_IGNORE = 6'h20
  } sbc_state_e;
  typedef enum logic [3:0] {
    K_ADDR = 4'h1,
    K_LOC = 4'h2,
    K_CNT = 4'h4,
    K_DATA = 4'h8
  } sbc_kind_e;
endpackage

//--- sbc_smbus_slave.sv
`timescale 1ns/1ns
module sbc_smbus_slave (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [2:0] i_address_select_pin,
  input wire logic i_cfg_hold,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [63:0] o_cfg_bytes
);
  // ==========================================================
  // pin synchronisers
  logic [4:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [1:0] prev_reg, prev_next;
  logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;

  always_comb begin
    sync1_next = {i_scl, i_sda, i_address_select_pin};
    sync2_next = sync1_reg;
    prev_next = sync2_reg[4:3];
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync1_reg <= 5'h18;
      sync2_reg <= 5'h18;
      prev_reg <= 2'h3;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
    end
  end

  assign scl_s = sync2_reg[4];
  assign sda_s = sync2_reg[3];
  assign scl_rise = scl_s && !prev_reg[1];
  assign scl_fall = !scl_s && prev_reg[1];
  assign start_ev = scl_s && prev_reg[1] && prev_reg[0] && !sda_s;
  assign stop_ev = scl_s && prev_reg[1] && !prev_reg[0] && sda_s;

  // ==========================================================
  // configuration store
  logic [7:0] cfg_reg [sbc_pkg::NUM_LOC];
  logic [7:0] cfg_next [sbc_pkg::NUM_LOC];
  logic fifo_ready, drain_valid, drain_ready, push_valid;
  logic [15:0] push_data, drain_data;

  function automatic logic loc_in_range(input logic [7:0] loc);
    loc_in_range = (loc < 8'(sbc_pkg::NUM_LOC));
  endfunction

  // out of range reads return zero
  function automatic logic [7:0] read_loc(input logic [7:0] loc,
                                          input logic [7:0] mem [sbc_pkg::NUM_LOC]);
    read_loc = loc_in_range(loc) ? mem[loc[2:0]] : 8'h00;
  endfunction

  // hold stalls the drain so a full buffer stretches the bus clock
  assign drain_ready = !i_cfg_hold;

  always_comb begin
    cfg_next = cfg_reg;
    if (drain_valid && drain_ready && loc_in_range(drain_data[15:8]) &&
        !sbc_pkg::RO_MASK[drain_data[10:8]]) begin
      cfg_next[drain_data[10:8]] = drain_data[7:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int i = 0; i < sbc_pkg::NUM_LOC; i++) begin
        cfg_reg[i] <= sbc_pkg::CFG_RESET[i*8 +: 8];
      end
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  always_comb begin
    for (int i = 0; i < sbc_pkg::NUM_LOC; i++) begin
      o_cfg_bytes[i*8 +: 8] = cfg_reg[i];
    end
  end

  sbc_fifo #(
    .WIDTH(sbc_pkg::FIFO_WIDTH),
    .DEPTH(sbc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_valid(push_valid),
    .o_ready(fifo_ready),
    .i_data(push_data),
    .o_valid(drain_valid),
    .i_ready(drain_ready),
    .o_data(drain_data)
  );

  // ==========================================================
  // protocol engine
  sbc_pkg::sbc_state_e state_reg, state_next;
  sbc_pkg::sbc_kind_e kind_reg, kind_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next, remain_reg, remain_next;
  logic [7:0] rd_byte;
  logic [6:0] my_addr_reg, my_addr_next;
  logic [1:0] lat_cnt_reg, lat_cnt_next;
  logic lat_done_reg, lat_done_next, rd_reg, rd_next, ack_ok_reg, ack_ok_next;
  logic sda_oe_reg, sda_oe_next, scl_oe_reg, scl_oe_next, byte_done;

  assign byte_done = (cnt_reg == 4'h8) && !scl_s;
  assign rd_byte = read_loc(ptr_reg, cfg_reg);
  assign push_data = {ptr_reg, shift_reg};

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    remain_next = remain_reg;
    rd_next = rd_reg;
    ack_ok_next = ack_ok_reg;
    sda_oe_next = sda_oe_reg;
    scl_oe_next = 1'b0;
    push_valid = 1'b0;
    my_addr_next = my_addr_reg;
    lat_cnt_next = lat_cnt_reg;
    lat_done_next = lat_done_reg;
    // strap caught once, after the synchroniser has settled
    if (!lat_done_reg) begin
      lat_cnt_next = 2'(lat_cnt_reg + 1'b1);
      if (lat_cnt_reg == sbc_pkg::LATCH_DELAY) begin
        my_addr_next = {sbc_pkg::ADDR_HIGH, sync2_reg[2:0]};
        lat_done_next = 1'b1;
      end
    end
    if (stop_ev) begin
      state_next = sbc_pkg::ST_IDLE;
      sda_oe_next = 1'b0;
    end else if (start_ev) begin
      state_next = sbc_pkg::ST_RX;
      kind_next = sbc_pkg::K_ADDR;
      cnt_next = 4'h0;
      sda_oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        sbc_pkg::ST_IDLE, sbc_pkg::ST_IGNORE: begin
        end
        sbc_pkg::ST_RX: begin
          if (scl_rise && cnt_reg != 4'h8) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next = 4'(cnt_reg + 1'b1);
          end else if (byte_done) begin
            unique case (kind_reg)
              sbc_pkg::K_ADDR: begin
                if (lat_done_reg && shift_reg[7:1] == my_addr_reg) begin
                  sda_oe_next = 1'b1;
                  state_next = sbc_pkg::ST_RX_ACK;
                  rd_next = shift_reg[0];
                  kind_next = sbc_pkg::K_LOC;
                end else begin
                  state_next = sbc_pkg::ST_IGNORE;
                end
              end
              sbc_pkg::K_LOC: begin
                ptr_next = shift_reg;
                sda_oe_next = 1'b1;
                state_next = sbc_pkg::ST_RX_ACK;
                kind_next = sbc_pkg::K_CNT;
              end
              sbc_pkg::K_CNT: begin
                remain_next = shift_reg;
                sda_oe_next = 1'b1;
                state_next = sbc_pkg::ST_RX_ACK;
                kind_next = sbc_pkg::K_DATA;
              end
              sbc_pkg::K_DATA: begin
                if (remain_reg == 8'h00) begin
                  state_next = sbc_pkg::ST_IGNORE;
                end else if (fifo_ready) begin
                  push_valid = 1'b1;
                  sda_oe_next = 1'b1;
                  state_next = sbc_pkg::ST_RX_ACK;
                  ptr_next = 8'(ptr_reg + 1'b1);
                  remain_next = 8'(remain_reg - 1'b1);
                end else begin
                  // stretch rather than lose a byte the host thinks was taken
                  scl_oe_next = 1'b1;
                end
              end
            endcase
          end
        end
        sbc_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            cnt_next = 4'h0;
            if (rd_reg) begin
              state_next = sbc_pkg::ST_TX;
              shift_next = sbc_pkg::BYTE_COUNT;
              sda_oe_next = !sbc_pkg::BYTE_COUNT[7];
            end else begin
              state_next = sbc_pkg::ST_RX;
              sda_oe_next = 1'b0;
            end
          end
        end
        sbc_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h7) begin
              sda_oe_next = 1'b0;
              state_next = sbc_pkg::ST_TX_ACK;
              cnt_next = 4'h0;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              sda_oe_next = !shift_reg[6];
              cnt_next = 4'(cnt_reg + 1'b1);
            end
          end
        end
        sbc_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            ack_ok_next = !sda_s;
          end else if (scl_fall) begin
            if (ack_ok_reg) begin
              state_next = sbc_pkg::ST_TX;
              shift_next = rd_byte;
              sda_oe_next = !rd_byte[7];
              ptr_next = 8'(ptr_reg + 1'b1);
            end else begin
              state_next = sbc_pkg::ST_IGNORE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= sbc_pkg::ST_IDLE;
      kind_reg <= sbc_pkg::K_ADDR;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      remain_reg <= 8'h00;
      rd_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      my_addr_reg <= 7'h00;
      lat_cnt_reg <= 2'h0;
      lat_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      remain_reg <= remain_next;
      rd_reg <= rd_next;
      ack_ok_reg <= ack_ok_next;
      sda_oe_reg <= sda_oe_next;
      scl_oe_reg <= scl_oe_next;
      my_addr_reg <= my_addr_next;
      lat_cnt_reg <= lat_cnt_next;
      lat_done_reg <= lat_done_next;
    end
  end

  // open drain: only ever pulls low
  assign o_sda_oe = sda_oe_reg;
  assign o_scl_oe = scl_oe_reg;
  assign o_sda_out = 1'b0;
  assign o_scl_out = 1'b0;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_addr_done;
    state_reg == sbc_pkg::ST_RX && kind_reg == sbc_pkg::K_ADDR && byte_done &&
      !start_ev && !stop_ev;
  endsequence
  sequence s_addr_match;
    s_addr_done and (lat_done_reg && shift_reg[7:1] == my_addr_reg);
  endsequence

  a_addr_ack_drive: assert property (s_addr_match |=> o_sda_oe &&
    state_reg == sbc_pkg::ST_RX_ACK) else $error("own address not acknowledged");
  a_addr_foreign_quiet: assert property ((s_addr_done and
    !(lat_done_reg && shift_reg[7:1] == my_addr_reg)) |=> state_reg == sbc_pkg::ST_IGNORE
    && !o_sda_oe) else $error("foreign address acknowledged");
  a_ignore_holds: assert property (state_reg == sbc_pkg::ST_IGNORE && !start_ev &&
    !stop_ev |=> state_reg == sbc_pkg::ST_IGNORE && !o_sda_oe) else $error("ignore left");
  a_dir_bit_taken: assert property (s_addr_match |=> rd_reg == $past(shift_reg[0]))
    else $error("direction bit lost");
  a_read_count_first: assert property (state_reg == sbc_pkg::ST_RX_ACK && rd_reg &&
    scl_fall && !start_ev && !stop_ev |=> state_reg == sbc_pkg::ST_TX &&
    shift_reg == sbc_pkg::BYTE_COUNT ##1 cnt_reg == 4'h0) else $error("count not sent first");
  a_push_counted: assert property (push_valid |-> remain_reg != 8'h00 ##1
    remain_reg == 8'($past(remain_reg) - 1'b1) && o_sda_oe) else $error("write count broken");
  a_stop_idle: assert property (stop_ev |=> state_reg == sbc_pkg::ST_IDLE && !o_sda_oe)
    else $error("stop did not idle");
  a_slave_only_scl: assert property (o_scl_oe |-> $past(kind_reg) == sbc_pkg::K_DATA &&
    $past(state_reg) == sbc_pkg::ST_RX && !$past(fifo_ready)) else $error("clock driven");
  a_nack_ends_read: assert property (state_reg == sbc_pkg::ST_TX_ACK && !ack_ok_reg &&
    scl_fall && !start_ev && !stop_ev |=> state_reg == sbc_pkg::ST_IGNORE [*2])
    else $error("read went on after nack");
endmodule // sbc_smbus_slave

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [7:0] n; logic [7:0] x; int k; logic [7:0] d;} sbc_row_s;
  logic clock, rst, cfg_hold, hang, h_scl, h_sda, scl_oe, sda_oe, scl_w, sda_w;
  logic scl_o, sda_o;
  logic [2:0] addr_pin;
  logic [6:0] addr;
  logic [63:0] cfg, snap;
  logic [7:0] exp_mem [8];
  int mismatches, total_checks, n;
  sbc_row_s rows [6];
  // open drain wires: pulled up unless someone drives its data value
  assign scl_w = ~h_scl & (scl_oe ? scl_o : 1'b1);
  assign sda_w = ~h_sda & (sda_oe ? sda_o : 1'b1);
  sbc_smbus_slave dut (.i_clock(clock), .i_rst(rst), .i_scl(scl_w), .i_sda(sda_w),
    .i_address_select_pin(addr_pin), .i_cfg_hold(cfg_hold), .o_scl_out(scl_o),
    .o_scl_oe(scl_oe), .o_sda_out(sda_o), .o_sda_oe(sda_oe), .o_cfg_bytes(cfg));
  sbc_host_model host (.i_clock(clock), .i_scl(scl_w), .i_sda(sda_w), .o_scl_low(h_scl),
    .o_sda_low(h_sda), .o_hang(hang));
  // ==========================================================
  // checking and verdict
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge hang) begin
    mismatches++;
    end_sim();
  end
  function automatic logic [63:0] exp_cfg();
    for (int k = 0; k < 8; k++) exp_cfg[8*k+:8] = exp_mem[k];
  endfunction
  // ==========================================================
  // block transfers
  task automatic blk_wr(input logic [6:0] a, input sbc_row_s r, input logic ok);
    logic ack;
    int loc;
    host.start_cond();
    host.wr_byte({a, 1'b0}, ack);
    check(ack, ok);
    host.wr_byte(r.n, ack);
    check(ack, ok);
    host.wr_byte(r.x, ack);
    check(ack, ok);
    for (int i = 0; i < r.k; i++) begin
      loc = int'(r.n) + i;
      host.wr_byte(r.d + 8'(i), ack);
      check(ack, ok && i < int'(r.x));
      if (ok && i < int'(r.x) && loc < 8 && loc != 5 && loc != 6) exp_mem[loc] = r.d + 8'(i);
    end
    host.stop_cond();
  endtask
  task automatic blk_rd(input logic [7:0] nloc, input int k);
    logic ack;
    logic [7:0] d;
    host.start_cond();
    host.wr_byte({addr, 1'b0}, ack);
    host.wr_byte(nloc, ack);
    host.start_cond();
    host.wr_byte({addr, 1'b1}, ack);
    check(ack, 1'b1);
    host.rd_byte(1'b0, d);
    check(d, sbc_pkg::BYTE_COUNT);
    for (int i = 0; i < k; i++) begin
      host.rd_byte(i == k - 1, d);
      check(d, (int'(nloc) + i < 8) ? exp_mem[int'(nloc) + i] : 8'h00);
    end
    host.stop_cond();
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    rst = 1'b0;
    for (int k = 0; k < 8; k++) exp_mem[k] = sbc_pkg::CFG_RESET[8*k+:8];
    check(cfg, sbc_pkg::CFG_RESET);
    check({scl_oe, sda_oe}, 2'h0);
    check({scl_o, sda_o}, 2'h0);
    repeat (12) @(posedge clock);
    #1;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    cfg_hold = 1'b0;
    addr_pin = 3'h5;
    addr = {sbc_pkg::ADDR_HIGH, 3'h5};
    mismatches = 0;
    total_checks = 0;
    // plain, spill into read-only, past the top, extra byte nacked
    rows = '{'{8'h00, 8'h01, 1, 8'ha0}, '{8'h01, 8'h03, 3, 8'hb1}, '{8'h03, 8'h02, 3, 8'hc0},
             '{8'h04, 8'h02, 2, 8'hd0}, '{8'h07, 8'h02, 2, 8'he0}, '{8'h09, 8'h01, 1, 8'hf0}};
    do_reset();
    foreach (rows[i]) begin
      blk_wr(addr, rows[i], 1'b1);
      check(cfg, exp_cfg());
    end
    blk_rd(8'h05, 4);
    blk_rd(8'h00, 2);
    blk_wr(addr ^ 7'h01, rows[0], 1'b0);
    blk_wr(addr ^ 7'h40, rows[0], 1'b0);
    check(cfg, exp_cfg());
    blk_wr(addr, '{8'h00, 8'h03, 1, 8'h77}, 1'b1);
    check(cfg, exp_cfg());
    blk_rd(8'h00, 1);
    // buffer fills while draining is held, target must stretch
    cfg_hold = 1'b1;
    snap = exp_cfg();
    fork
      begin
        blk_wr(addr, '{8'h00, 8'h05, 5, 8'h10}, 1'b1);
        blk_wr(addr, '{8'h00, 8'h05, 5, 8'h20}, 1'b1);
      end
      begin
        n = 0;
        while (scl_oe !== 1'b1 && n < 3000) begin
          @(posedge clock);
          #1;
          n++;
        end
        check(scl_oe, 1'b1);
        check(cfg, snap);
        cfg_hold = 1'b0;
      end
    join
    repeat (4) @(posedge clock);
    #1;
    check(cfg, exp_cfg());
    blk_rd(8'h00, 8);
    // new strap level only takes effect at the latch after reset
    addr_pin = 3'h2;
    addr = {sbc_pkg::ADDR_HIGH, 3'h2};
    do_reset();
    blk_wr(addr ^ 7'h07, rows[0], 1'b0);
    blk_wr(addr, rows[1], 1'b1);
    check(cfg, exp_cfg());
    end_sim();
  end
endmodule // tb_top
